// *** design/jtag_tap_map.svh ***
// Opcodes, register layouts, capture values and sizes of the boundary-scan test port
`ifndef JTAG_TAP_MAP_SVH
`define JTAG_TAP_MAP_SVH

`define IR_WIDTH 5
`define IR_CAPTURE 5'h01
`define OP_EXTEST 5'h00
`define OP_SAMPLE 5'h01
`define OP_INT_SCAN 5'h02
`define OP_CLAMP 5'h04
`define OP_HIGHZ 5'h05
`define OP_SELFTEST 5'h0a
`define OP_IDCODE 5'h0c
`define OP_BYPASS 5'h1f

`define ID_WIDTH 32
`define ID_VER_MSB 31
`define ID_VER_LSB 28
`define ID_PART_MSB 27
`define ID_PART_LSB 12
`define ID_MFR_MSB 11
`define ID_MFR_LSB 1
`define ID_FIXED_BIT 1'b1

`define BSR_NIN 4
`define BSR_NOUT 4
`define BSR_NBI 2
`define BSR_IN_LSB 0
`define BSR_OUT_LSB 4
`define BSR_OEN_LSB 8
`define BSR_BD_LSB 12
`define BSR_BOE_LSB 14
`define BSR_BI_LSB 16
`define BSR_LEN 18

`define SYNC_W 3
`define TDO_BUF_DEPTH 2

`endif

// *** design/jtag_tap_pkg.sv ***
// Types shared by the boundary-scan test port
package jtag_tap_pkg;

  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pa_dr, st_ex2_dr,
    st_up_dr, st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pa_ir, st_ex2_ir, st_up_ir
  } tap_state_type;

  typedef enum logic [2:0] {
    sel_bypass, sel_ident, sel_bsr, sel_scan, sel_selftest
  } dr_sel_type;

endpackage

// *** design/tdo_skid_buffer.sv ***
// Two-entry valid/ready buffer between the serial-out source and the output driver
`timescale 1ns/1ps
module tdo_skid_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic do_push;
  logic do_pop;

  assign o_in_ready = (count_reg != (PW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data = mem_reg[rd_ptr_reg];
  assign do_push = i_in_valid && o_in_ready;
  assign do_pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk)
  begin
    if (do_push)
    begin
      mem_reg[wr_ptr_reg] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (do_pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      if (do_push && !do_pop)
      begin
        count_reg <= count_reg + (PW+1)'(1);
      end
      else if (!do_push && do_pop)
      begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end

endmodule

// *** design/jtag_boundary_scan_tap.sv ***
// Boundary-scan test access port: TAP controller, instruction and data registers
// Summary of operation
// - Sixteen-state TAP controller advances on each sampled TCK rise, steered by TMS.
// - Dedicated power-on reset puts the controller into Test-Logic-Reset, independent.
// - Five-bit instruction register; its decode picks operation and TDI-TDO data register.
// - Unassigned instruction codes act exactly like the all-ones bypass instruction.
// - Code 00000 selects boundary register, drives outputs from cells, captures inputs.
// - Code 00001 captures pin states and preloads cells without disturbing the pins.
// - Code 00101 floats all outputs and bidirectionals except TDO; bypass shifts.
// - Code 00100 holds pins from boundary cells while bypass forms the serial path.
// - Code 01100 places the 32-bit identification register between TDI and TDO.
// - Code 00010 selects internal scan chain; 01010 selects memory self-test register.
// - Bypass is a single-bit stage giving the shortest TDI-to-TDO path.
// - Identification: version 31:28, part 27:12, maker 11:1, constant one in bit 0.
// - Boundary chain covers every digital signal pin, not supply or test pins.
// - Boundary register uses four cell kinds, chosen by each pin's function.
// - Boundary cells are dedicated test logic outside the normal system path.
// - Under sample and external test, cells load in parallel on TCK rise.
`timescale 1ns/1ps
`include "jtag_tap_map.svh"
module jtag_boundary_scan_tap
  import jtag_tap_pkg::*;
#(
  parameter logic [3:0] ID_VERSION = 4'h3,     // Arbitrary value
  parameter logic [15:0] ID_PART = 16'h4b2d,   // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h0a6    // Arbitrary value
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe_n,
  input wire logic [`BSR_NIN-1:0] i_pin_in,
  output logic [`BSR_NIN-1:0] o_core_in,
  input wire logic [`BSR_NOUT-1:0] i_core_out,
  input wire logic [`BSR_NOUT-1:0] i_core_out_oe_n,
  output logic [`BSR_NOUT-1:0] o_pin_out,
  output logic [`BSR_NOUT-1:0] o_pin_out_oe_n,
  input wire logic [`BSR_NBI-1:0] i_bidir_in,
  output logic [`BSR_NBI-1:0] o_bidir_out,
  output logic [`BSR_NBI-1:0] o_bidir_oe_n,
  input wire logic [`BSR_NBI-1:0] i_core_bidir_out,
  input wire logic [`BSR_NBI-1:0] i_core_bidir_oe_n,
  output logic [`BSR_NBI-1:0] o_core_bidir_in,
  output logic o_chain_si,
  output logic o_scan_mode,
  output logic o_scan_capture,
  output logic o_scan_shift,
  input wire logic i_scan_so,
  output logic o_selftest_mode,
  output logic o_selftest_capture,
  output logic o_selftest_shift,
  output logic o_selftest_update,
  input wire logic i_selftest_so
);

  localparam int PIN_W = `SYNC_W + `BSR_NIN + `BSR_NBI;

  logic rst_meta_reg, rst_n;
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg;
  logic tck_prev_reg, tck_s, tms_s, tdi_s, tck_rise, tck_fall;
  logic [`BSR_NIN-1:0] pin_in_s;
  logic [`BSR_NBI-1:0] bidir_in_s;

  tap_state_type state_reg, state_next;
  logic [`IR_WIDTH-1:0] ir_shift_reg, ir_reg;
  dr_sel_type dr_sel;
  logic op_extest, op_sample, op_clamp, op_highz, bypass_reg;
  logic [`ID_WIDTH-1:0] id_shift_reg, id_value;
  logic [`BSR_LEN-1:0] bsr_shift_reg, bsr_upd_reg, bsr_capture;
  logic serial_out, shifting, buf_out_valid;
  logic [1:0] buf_out_data;

  // Reset release
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      tck_prev_reg <= 1'b0;
      o_chain_si <= 1'b0;
    end
    else
    begin
      pin_meta_reg <= {i_bidir_in, i_pin_in, i_tdi, i_tms, i_tck};
      pin_sync_reg <= pin_meta_reg;
      tck_prev_reg <= pin_sync_reg[0];
      o_chain_si <= tdi_s;
    end
  end

  assign tck_s = pin_sync_reg[0];
  assign tms_s = pin_sync_reg[1];
  assign tdi_s = pin_sync_reg[2];
  assign pin_in_s = pin_sync_reg[`SYNC_W +: `BSR_NIN];
  assign bidir_in_s = pin_sync_reg[`SYNC_W + `BSR_NIN +: `BSR_NBI];
  assign tck_rise = tck_s && !tck_prev_reg;
  assign tck_fall = !tck_s && tck_prev_reg;
  assign o_core_in = pin_in_s;
  assign o_core_bidir_in = bidir_in_s;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_reset: state_next = tms_s ? st_reset : st_idle;
      st_idle: state_next = tms_s ? st_sel_dr : st_idle;
      st_sel_dr: state_next = tms_s ? st_sel_ir : st_cap_dr;
      st_cap_dr: state_next = tms_s ? st_ex1_dr : st_sh_dr;
      st_sh_dr: state_next = tms_s ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: state_next = tms_s ? st_up_dr : st_pa_dr;
      st_pa_dr: state_next = tms_s ? st_ex2_dr : st_pa_dr;
      st_ex2_dr: state_next = tms_s ? st_up_dr : st_sh_dr;
      st_up_dr: state_next = tms_s ? st_sel_dr : st_idle;
      st_sel_ir: state_next = tms_s ? st_reset : st_cap_ir;
      st_cap_ir: state_next = tms_s ? st_ex1_ir : st_sh_ir;
      st_sh_ir: state_next = tms_s ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: state_next = tms_s ? st_up_ir : st_pa_ir;
      st_pa_ir: state_next = tms_s ? st_ex2_ir : st_pa_ir;
      st_ex2_ir: state_next = tms_s ? st_up_ir : st_sh_ir;
      st_up_ir: state_next = tms_s ? st_sel_dr : st_idle;
    endcase
  end

  // The test port reset stands apart from any other reset of the device
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= st_reset;
    else if (tck_rise)
      state_reg <= state_next;
  end

  // Instruction register; reset loads the identification instruction
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_shift_reg <= `IR_CAPTURE;
      ir_reg <= `OP_IDCODE;
    end
    else if (tck_rise)
    begin
      unique case (state_reg)
        st_reset: ir_reg <= `OP_IDCODE;
        st_cap_ir: ir_shift_reg <= `IR_CAPTURE;
        st_sh_ir: ir_shift_reg <= {tdi_s, ir_shift_reg[`IR_WIDTH-1:1]};
        st_up_ir: ir_reg <= ir_shift_reg;
        default: ir_reg <= ir_reg;
      endcase
    end
  end

  always_comb
  begin
    op_extest = 1'b0;
    op_sample = 1'b0;
    op_clamp = 1'b0;
    op_highz = 1'b0;
    dr_sel = sel_bypass;
    unique case (ir_reg)
      `OP_EXTEST:
      begin
        op_extest = 1'b1;
        dr_sel = sel_bsr;
      end
      `OP_SAMPLE:
      begin
        op_sample = 1'b1;
        dr_sel = sel_bsr;
      end
      `OP_HIGHZ: op_highz = 1'b1;
      `OP_CLAMP: op_clamp = 1'b1;
      `OP_IDCODE: dr_sel = sel_ident;
      `OP_INT_SCAN: dr_sel = sel_scan;
      `OP_SELFTEST: dr_sel = sel_selftest;
      default: dr_sel = sel_bypass;
    endcase
  end

  assign id_value = {ID_VERSION, ID_PART, ID_MAKER, `ID_FIXED_BIT};

  // Four cell kinds: input, output data, output control, bidirectional
  // Every digital signal pin has a cell; the test port pins have none
  assign bsr_capture = {bidir_in_s, i_core_bidir_oe_n, i_core_bidir_out,
                        i_core_out_oe_n, i_core_out, pin_in_s};

  // Data registers
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bypass_reg <= 1'b0;
      id_shift_reg <= '0;
      bsr_shift_reg <= '0;
    end
    else if (tck_rise && state_reg == st_cap_dr)
    begin
      bypass_reg <= 1'b0;
      if (dr_sel == sel_ident)
      begin
        id_shift_reg <= id_value;
      end
      if (dr_sel == sel_bsr && (op_sample || op_extest))
      begin
        bsr_shift_reg <= bsr_capture;
      end
    end
    else if (tck_rise && state_reg == st_sh_dr)
    begin
      unique case (dr_sel)
        sel_bypass: bypass_reg <= tdi_s;
        sel_ident: id_shift_reg <= {tdi_s, id_shift_reg[`ID_WIDTH-1:1]};
        sel_bsr: bsr_shift_reg <= {tdi_s, bsr_shift_reg[`BSR_LEN-1:1]};
        sel_scan: bypass_reg <= bypass_reg;
        sel_selftest: bypass_reg <= bypass_reg;
      endcase
    end
  end

  // Update latches change only on update, so preloading never touches live pins
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
      bsr_upd_reg <= {`BSR_LEN{1'b1}};
    else if (tck_rise && state_reg == st_up_dr && dr_sel == sel_bsr)
      bsr_upd_reg <= bsr_shift_reg;
  end

  // Pin drive: cells in the path only for external test and clamp; high-Z forces all enables off; core path otherwise
  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pin_out <= '0;
      o_pin_out_oe_n <= '1;
      o_bidir_out <= '0;
      o_bidir_oe_n <= '1;
    end
    else if (op_highz)
    begin
      o_pin_out <= i_core_out;
      o_pin_out_oe_n <= '1;
      o_bidir_out <= i_core_bidir_out;
      o_bidir_oe_n <= '1;
    end
    else if (op_extest || op_clamp)
    begin
      o_pin_out <= bsr_upd_reg[`BSR_OUT_LSB +: `BSR_NOUT];
      o_pin_out_oe_n <= bsr_upd_reg[`BSR_OEN_LSB +: `BSR_NOUT];
      o_bidir_out <= bsr_upd_reg[`BSR_BD_LSB +: `BSR_NBI];
      o_bidir_oe_n <= bsr_upd_reg[`BSR_BOE_LSB +: `BSR_NBI];
    end
    else
    begin
      o_pin_out <= i_core_out;
      o_pin_out_oe_n <= i_core_out_oe_n;
      o_bidir_out <= i_core_bidir_out;
      o_bidir_oe_n <= i_core_bidir_oe_n;
    end
  end

  // External chains see one strobe per TCK rise in the matching state
  assign o_scan_mode = (dr_sel == sel_scan);
  assign o_scan_capture = o_scan_mode && tck_rise && state_reg == st_cap_dr;
  assign o_scan_shift = o_scan_mode && tck_rise && state_reg == st_sh_dr;
  assign o_selftest_mode = (dr_sel == sel_selftest);
  assign o_selftest_capture = o_selftest_mode && tck_rise && state_reg == st_cap_dr;
  assign o_selftest_shift = o_selftest_mode && tck_rise && state_reg == st_sh_dr;
  assign o_selftest_update = o_selftest_mode && tck_rise && state_reg == st_up_dr;

  always_comb
  begin
    serial_out = bypass_reg;
    if (state_reg == st_sh_ir)
      serial_out = ir_shift_reg[0];
    else
      unique case (dr_sel)
        sel_bypass: serial_out = bypass_reg;
        sel_ident: serial_out = id_shift_reg[0];
        sel_bsr: serial_out = bsr_shift_reg[0];
        sel_scan: serial_out = i_scan_so;
        sel_selftest: serial_out = i_selftest_so;
      endcase
  end

  assign shifting = (state_reg == st_sh_ir) || (state_reg == st_sh_dr);

  // Each TCK fall queues the next TDO level; the driver drains only while TCK
  // stays low, so a word caught near a rising edge waits rather than being lost
  tdo_skid_buffer #(
    .WIDTH(2),
    .DEPTH(`TDO_BUF_DEPTH)
  ) u_tdo_buf (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_in_valid(tck_fall),
    .o_in_ready(),
    .i_in_data({shifting, serial_out}),
    .o_out_valid(buf_out_valid),
    .i_out_ready(!tck_s),
    .o_out_data(buf_out_data)
  );

  always_ff @(posedge i_mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_tdo <= 1'b0;
      o_tdo_oe_n <= 1'b1;
    end
    else if (buf_out_valid && !tck_s)
    begin
      o_tdo <= buf_out_data[0];
      o_tdo_oe_n <= !buf_out_data[1];
    end
  end

endmodule

// *** bench/jtag_tap_sva.sv ***
// Port-level checker for the boundary-scan test port
`timescale 1ns/1ps
`include "jtag_tap_map.svh"
module jtag_tap_sva (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_tck,
  input wire logic i_tdi,
  input wire logic o_tdo,
  input wire logic o_tdo_oe_n,
  input wire logic [`BSR_NIN-1:0] i_pin_in,
  input wire logic [`BSR_NIN-1:0] o_core_in,
  input wire logic o_chain_si,
  input wire logic o_scan_mode,
  input wire logic o_scan_capture,
  input wire logic o_scan_shift,
  input wire logic o_selftest_mode,
  input wire logic o_selftest_capture,
  input wire logic o_selftest_shift,
  input wire logic o_selftest_update
);
  logic tck_reg;
  logic [3:0] fall_reg;
  logic [3:0] rise_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      tck_reg <= 1'b0;
    else
      tck_reg <= i_tck;
  // Cycles since a pin edge; saturates so long idle spans never wrap
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      fall_reg <= 4'hf;
    else if (tck_reg && !i_tck)
      fall_reg <= 4'h0;
    else if (fall_reg != 4'hf)
      fall_reg <= fall_reg + 4'h1;
  always_ff @(posedge i_mclk or negedge i_arst_n)
    if (!i_arst_n)
      rise_reg <= 4'hf;
    else if (!tck_reg && i_tck)
      rise_reg <= 4'h0;
    else if (rise_reg != 4'hf)
      rise_reg <= rise_reg + 4'h1;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  sequence s_pins_steady;
    $stable(i_pin_in) [*8];
  endsequence
  sequence s_tdi_steady;
    $stable(i_tdi) [*8];
  endsequence
  property p_tdo_after_fall;
    $changed(o_tdo) || $changed(o_tdo_oe_n) |-> fall_reg inside {[4'h2:4'h5]};
  endproperty
  a_tdo_after_fall: assert property (p_tdo_after_fall) else $error("tdo moved off fall");
  property p_shift_after_rise;
    o_scan_shift || o_selftest_shift |-> rise_reg <= 4'h3;
  endproperty
  a_shift_after_rise: assert property (p_shift_after_rise) else $error("shift off rise");
  property p_capture_mode;
    o_scan_capture || o_selftest_capture |->
      rise_reg <= 4'h3 && (o_scan_mode || o_selftest_mode);
  endproperty
  a_capture_mode: assert property (p_capture_mode) else $error("capture off rise");
  property p_scan_shift_mode;
    o_scan_shift |-> o_scan_mode;
  endproperty
  a_scan_shift_mode: assert property (p_scan_shift_mode) else $error("scan shift no mode");
  property p_st_shift_mode;
    o_selftest_shift |-> o_selftest_mode;
  endproperty
  a_st_shift_mode: assert property (p_st_shift_mode) else $error("selftest shift no mode");
  property p_st_update_mode;
    o_selftest_update |-> o_selftest_mode && !o_selftest_shift;
  endproperty
  a_st_update_mode: assert property (p_st_update_mode) else $error("bad update");
  property p_one_mode;
    !(o_scan_mode && o_selftest_mode);
  endproperty
  a_one_mode: assert property (p_one_mode) else $error("two modes at once");
  property p_core_in;
    s_pins_steady |-> o_core_in == i_pin_in;
  endproperty
  a_core_in: assert property (p_core_in) else $error("core input disturbed");
  property p_chain_si;
    s_tdi_steady |-> o_chain_si == i_tdi;
  endproperty
  a_chain_si: assert property (p_chain_si) else $error("chain input wrong");
endmodule
bind jtag_boundary_scan_tap jtag_tap_sva u_sva (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
  .i_tck(i_tck), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .i_pin_in(i_pin_in),
  .o_core_in(o_core_in), .o_chain_si(o_chain_si), .o_scan_mode(o_scan_mode),
  .o_scan_capture(o_scan_capture), .o_selftest_capture(o_selftest_capture),
  .o_scan_shift(o_scan_shift), .o_selftest_mode(o_selftest_mode),
  .o_selftest_shift(o_selftest_shift), .o_selftest_update(o_selftest_update));

// *** bench/jtag_test_ctl.sv ***
// Board test controller model driving the serial test port
`timescale 1ns/1ps
module jtag_test_ctl (
  input wire logic i_mclk,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo,
  input wire logic i_tdo_oe_n
);
  logic tdo_line;
  // A released line reads inverted so a float never passes as data
  assign tdo_line = i_tdo_oe_n ? ~i_tdo : i_tdo;
  initial
  begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // TCK rests low between frames; TMS and TDI move only while it is low
  task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
    @(negedge i_mclk);
    o_tms = tms_v;
    o_tdi = tdi_v;
    repeat (3) @(negedge i_mclk);
    tdo_v = tdo_line;
    o_tck = 1'b1;
    repeat (4) @(negedge i_mclk);
    o_tck = 1'b0;
  endtask
  task automatic move(input logic [7:0] path, input int n);
    logic d;
    for (int i = 0; i < n; i++)
      tick(path[i], 1'b0, d);
  endtask
  task automatic scan(input logic ir, input logic [31:0] din, output logic [31:0] dout);
    move(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < 32; i++)
      tick(i == 31, din[i], dout[i]);
    move(8'h01, 2);
  endtask
endmodule

// *** bench/tb_top.sv ***
// Testbench for the boundary-scan test port
`timescale 1ns/1ps
`include "jtag_tap_map.svh"
module tb_top;
  localparam logic [31:0] ID = {4'h5, 16'h1234, 11'h155, 1'b1};
  localparam logic [17:0] P = {2'h0, 2'h1, 2'h2, 4'h3, 4'h9, 4'h0};
  logic mclk, arst_n, tck, tms, tdi, tdo, tdo_oe_n, chain_si, scan_mode, scan_so, st_mode, st_so;
  logic [3:0] pin_in, core_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [1:0] bi_in, bi_out, bi_oe_n, cbi_out, cbi_oe_n, cbi_in;
  logic [31:0] dout;
  logic [4:0] byp [5] = '{`OP_CLAMP, `OP_HIGHZ, 5'h03, 5'h1e, `OP_BYPASS};
  int n_errors = 0;
  int n_tests = 0;
  // Identity values are arbitrary
  jtag_boundary_scan_tap #(.ID_VERSION(4'h5), .ID_PART(16'h1234), .ID_MAKER(11'h155)) uut (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .o_tdo(tdo),
    .o_tdo_oe_n(tdo_oe_n), .i_pin_in(pin_in), .o_core_in(core_in), .i_core_out(core_out),
    .i_core_out_oe_n(core_oe_n), .o_pin_out(pin_out), .o_pin_out_oe_n(pin_oe_n),
    .i_bidir_in(bi_in), .o_bidir_out(bi_out), .o_bidir_oe_n(bi_oe_n),
    .i_core_bidir_out(cbi_out), .i_core_bidir_oe_n(cbi_oe_n), .o_core_bidir_in(cbi_in),
    .o_chain_si(chain_si), .o_scan_mode(scan_mode), .o_scan_capture(), .o_scan_shift(),
    .i_scan_so(scan_so), .o_selftest_mode(st_mode), .o_selftest_capture(),
    .o_selftest_shift(), .o_selftest_update(), .i_selftest_so(st_so));
  jtag_test_ctl ctl (.i_mclk(mclk), .o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo),
    .i_tdo_oe_n(tdo_oe_n));
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic load(input logic [4:0] code);
    ctl.scan(1'b1, {code, 27'h0}, dout);
    check("ir capture", dout[4:0], `IR_CAPTURE);
  endtask
  task automatic dr(input logic [31:0] din);
    ctl.scan(1'b0, din, dout);
    check("tdo idle", tdo_oe_n, 1'b1);
  endtask
  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  initial
  begin
    arst_n = 1'b0;
    pin_in = 4'ha;
    core_out = 4'h5;
    core_oe_n = 4'h0;
    bi_in = 2'h2;
    cbi_out = 2'h1;
    cbi_oe_n = 2'h0;
    scan_so = 1'b1;
    st_so = 1'b0;
    repeat (8) @(negedge mclk);
    arst_n = 1'b1;
    repeat (8) @(negedge mclk);
    check("pins", {pin_oe_n, pin_out}, {core_oe_n, core_out});
    check("core in", {cbi_in, core_in}, {bi_in, pin_in});
    ctl.move(8'h00, 1);
    dr(32'h0);
    check("id", dout, ID);
    load(`OP_SAMPLE);
    dr({P, 14'h0});
    check("capture", dout[17:0], {bi_in, cbi_oe_n, cbi_out, core_oe_n, core_out, pin_in});
    check("chain tail", dout[31:18], 14'h0);
    check("pins kept", {pin_oe_n, pin_out}, 8'h05);
    load(`OP_EXTEST);
    check("drive", {bi_oe_n, bi_out, pin_oe_n, pin_out}, 12'h639);
    pin_in = 4'h6;
    dr({P, 14'h0});
    check("extest capture", dout[3:0], 4'h6);
    foreach (byp[i])
    begin
      load(byp[i]);
      if (byp[i] == `OP_HIGHZ)
        check("float", {bi_oe_n, pin_oe_n}, 6'h3f);
      if (byp[i] == `OP_CLAMP)
        check("clamp", {bi_oe_n, bi_out, pin_oe_n, pin_out}, 12'h639);
      dr(32'hc3a5_0f96);
      check("one bit path", dout, {31'h43a5_0f96, 1'b0});
    end
    load(`OP_IDCODE);
    dr(32'h0);
    check("id again", dout, ID);
    load(`OP_INT_SCAN);
    check("scan mode", {scan_mode, st_mode}, 2'h2);
    dr(32'hffff_ffff);
    check("scan chain", dout, 32'hffff_ffff);
    load(`OP_SELFTEST);
    check("selftest mode", {scan_mode, st_mode}, 2'h1);
    dr(32'hffff_ffff);
    check("selftest chain", dout, 32'h0);
    ctl.move(8'h1f, 6);
    dr(32'h0);
    check("id after tms reset", dout, ID);
    complete_run();
  end
endmodule
